// File: core/sram_host_pkg.sv
package sram_host_pkg;

    // ------------------------------------------------------------------
    // Memory organisation.
    // ------------------------------------------------------------------
    localparam int ADDR_W = 18;
    localparam int DATA_W = 4;

    // ------------------------------------------------------------------
    // Pin timing of the memory, in nanoseconds, and the core clock.
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS           = 40;
    localparam int SELECT_TO_DATA_MAX_NS   = 17;
    localparam int ADDR_TO_DATA_MAX_NS     = 17;
    localparam int ENABLE_TO_DATA_MAX_NS   = 9;
    localparam int DESELECT_TO_FLOAT_MAX_NS = 8;
    localparam int DISABLE_TO_FLOAT_MAX_NS = 7;
    localparam int WRITE_PULSE_MIN_NS      = 12;
    localparam int SELECT_TO_WRITE_END_NS  = 12;
    localparam int ADDR_VALID_TO_WRITE_END_NS = 12;
    localparam int DATA_SETUP_TO_WRITE_END_NS = 9;
    localparam int WRITE_CYCLE_MIN_NS      = 17;

    // Least times round up to whole cycles, never below one.
    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : ns_to_cyc

    localparam int READ_WAIT_CYC  = ns_to_cyc(SELECT_TO_DATA_MAX_NS);
    localparam int WRITE_LOW_CYC  = ns_to_cyc(WRITE_PULSE_MIN_NS);
    localparam int FLOAT_WAIT_CYC = ns_to_cyc(DESELECT_TO_FLOAT_MAX_NS);
    localparam int CNT_W          = 4;

    // ------------------------------------------------------------------
    // Controller states.
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_READ  = 5'h02,
        ST_WRITE = 5'h04,
        ST_FLOAT = 5'h08,
        ST_DONE  = 5'h10
    } state_t;

endpackage : sram_host_pkg

// File: core/sram_host_ctrl.sv
// Notes on behaviour
// [RULE_01] Memory holds 256K words of four bits.
// [RULE_02] Controls are select, output enable, write strobe.
// [RULE_03] No clock to memory; pin levels only.
// [RULE_04] Read: strobe high, select and enable low.
// [RULE_05] Sample read data after access time elapses.
// [RULE_06] Address is valid before select falls; the controller changes both on the same clock edge.
// [RULE_07] Old data held briefly after address change.
// [RULE_08] Memory drives no earlier than select fall.
// [RULE_09] Memory floats within time after deselect.
// [RULE_10] Data valid soon after enable falls.
// [RULE_11] Memory floats soon after enable rises.
// [RULE_12] Memory powers down after deselection.
// [RULE_13] Write happens while select and strobe low.
// [RULE_14] Address changes only while strobe high.
// [RULE_15] Address valid long enough before write end.
// [RULE_16] Select held low long enough before write end.
// [RULE_17] Write data valid before end, held after.
// [RULE_18] Enable low write needs longer strobe pulse.
// [RULE_19] Enable high write needs plain pulse only.
// [RULE_20] Memory floats after strobe falls.
// [RULE_21] Select after strobe keeps memory outputs off.
// [RULE_22] Controller never drives while memory drives.
// [RULE_23] Deselected memory floats and ignores controls.
`timescale 1ns/100ps
module sram_host_ctrl #(
    parameter int READ_CYC  = sram_host_pkg::READ_WAIT_CYC,
    parameter int WRITE_CYC = sram_host_pkg::WRITE_LOW_CYC
) (
    input  wire logic                           CORE_CLK_I,
    input  wire logic                           ARST_N_I,
    input  wire logic                           REQ_VALID_I,
    input  wire logic                           REQ_WRITE_I,
    input  wire logic [sram_host_pkg::ADDR_W-1:0] REQ_ADDR_I,
    input  wire logic [sram_host_pkg::DATA_W-1:0] REQ_WDATA_I,
    output logic                                REQ_READY_O,
    output logic                                RSP_VALID_O,
    output logic [sram_host_pkg::DATA_W-1:0]    RSP_RDATA_O,
    output logic [sram_host_pkg::ADDR_W-1:0]    MEM_ADDR_O,
    output logic                                MEM_SEL_N_O,
    output logic                                MEM_OE_N_O,
    output logic                                MEM_WRITE_STROBE_N_O,
    input  wire logic [sram_host_pkg::DATA_W-1:0] MEM_DATA_I,
    output logic [sram_host_pkg::DATA_W-1:0]    MEM_DATA_O,
    output logic                                MEM_DATA_OE_O
);
    import sram_host_pkg::*;

    // ------------------------------------------------------------------
    // Input synchroniser for the shared data pins.
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] data_meta;
    logic [DATA_W-1:0] data_sync;

    // The first stage feeds only the second; the pins are asynchronous.
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            data_meta <= '0;
            data_sync <= '0;
        end else begin
            data_meta <= MEM_DATA_I;
            data_sync <= data_meta;
        end
    end

    // ------------------------------------------------------------------
    // Sequencer.
    // ------------------------------------------------------------------
    state_t           state;
    state_t           next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;

    // Two extra cycles cover the synchroniser delay on read data.
    localparam logic [CNT_W-1:0] RD_LOAD = CNT_W'(READ_CYC + 2);
    localparam logic [CNT_W-1:0] WR_LOAD = CNT_W'(WRITE_CYC);
    localparam logic [CNT_W-1:0] FL_LOAD = CNT_W'(FLOAT_WAIT_CYC);
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

    wire take     = (state == ST_IDLE) && REQ_VALID_I;
    wire cnt_done = (cnt == CNT_ONE);

    // Next-state selection; counters load on entry to each timed phase.
    always_comb begin
        next_state = state;
        next_cnt   = (cnt > CNT_ONE) ? cnt - CNT_ONE : cnt;
        case (state)
            ST_IDLE: begin
                if (take) begin
                    next_state = REQ_WRITE_I ? ST_WRITE : ST_READ;
                    next_cnt   = REQ_WRITE_I ? WR_LOAD : RD_LOAD;
                end
            end
            ST_READ: begin
                if (cnt_done) begin
                    next_state = ST_FLOAT;
                    next_cnt   = FL_LOAD;
                end
            end
            ST_WRITE: begin
                if (cnt_done) begin
                    next_state = ST_DONE;
                end
            end
            ST_FLOAT: begin
                if (cnt_done) begin
                    next_state = ST_DONE;
                end
            end
            ST_DONE: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            state <= ST_IDLE;
            cnt   <= '0;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end

    // ------------------------------------------------------------------
    // Pin drive.
    // ------------------------------------------------------------------
    // Address is latched on acceptance and held through the whole
    // access; it changes on the same clock edge that select falls and never moves while
    // the strobe is low. The write is select-led with output enable
    // high, so the memory never drives during it and the plain pulse
    // width suffices.
    wire rd_next = (next_state == ST_READ);
    wire wr_next = (next_state == ST_WRITE);

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            MEM_ADDR_O           <= '0;
            MEM_SEL_N_O          <= 1'b1;
            MEM_OE_N_O           <= 1'b1;
            MEM_WRITE_STROBE_N_O <= 1'b1;
            MEM_DATA_O           <= '0;
            MEM_DATA_OE_O        <= 1'b0;
        end else begin
            if (take) begin
                MEM_ADDR_O <= REQ_ADDR_I; // RULE_06 RULE_14 RULE_15
                MEM_DATA_O <= REQ_WDATA_I; // RULE_17
            end
            MEM_SEL_N_O          <= !(rd_next || wr_next); // RULE_16
            MEM_OE_N_O           <= !rd_next; // RULE_04 RULE_18 RULE_19
            MEM_WRITE_STROBE_N_O <= !wr_next; // RULE_13
            // Write data is held one cycle past the strobe rise, so the
            // memory latches a settled word instead of racing the release.
            MEM_DATA_OE_O        <= wr_next || (state == ST_WRITE); // RULE_22
        end
    end

    // ------------------------------------------------------------------
    // Request and answer handshake.
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            REQ_READY_O <= 1'b0;
            RSP_VALID_O <= 1'b0;
            RSP_RDATA_O <= '0;
        end else begin
            REQ_READY_O <= (next_state == ST_IDLE);
            RSP_VALID_O <= (state == ST_WRITE || state == ST_FLOAT)
                           && cnt_done;
            if (state == ST_READ && cnt_done) begin
                RSP_RDATA_O <= data_sync; // RULE_05
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------
    property p_no_drive_in_read;
        @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
        !MEM_OE_N_O |-> !MEM_DATA_OE_O;
    endproperty
    a_no_drive_in_read: assert property (p_no_drive_in_read) // RULE_22
        else $error("Controller drives data while memory enabled.");

    property p_addr_stable_write;
        @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
        $changed(MEM_ADDR_O)
            |-> $past(MEM_WRITE_STROBE_N_O) || $past(MEM_SEL_N_O);
    endproperty
    a_addr_stable_write: assert property (p_addr_stable_write) // RULE_14
        else $error("Address moved during write.");

    property p_write_pulse;
        @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
        $fell(MEM_WRITE_STROBE_N_O) |-> !MEM_WRITE_STROBE_N_O[*1]
            ##0 !MEM_SEL_N_O;
    endproperty
    a_write_pulse: assert property (p_write_pulse) // RULE_16
        else $error("Write pulse without select.");

    property p_write_oe_high;
        @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
        !MEM_WRITE_STROBE_N_O |-> MEM_OE_N_O && MEM_DATA_OE_O;
    endproperty
    a_write_oe_high: assert property (p_write_oe_high) // RULE_19
        else $error("Write with enable low or no data.");

    property p_read_pins;
        @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
        !MEM_OE_N_O |-> !MEM_SEL_N_O && MEM_WRITE_STROBE_N_O;
    endproperty
    a_read_pins: assert property (p_read_pins) // RULE_04
        else $error("Read pin pattern wrong.");

    property p_read_wait;
        @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
        $fell(MEM_OE_N_O) |-> !MEM_OE_N_O[*3];
    endproperty
    a_read_wait: assert property (p_read_wait) // RULE_05
        else $error("Read ended before access time.");

    property p_float_gap;
        @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
        $rose(MEM_OE_N_O) |-> !MEM_DATA_OE_O ##1 !MEM_DATA_OE_O;
    endproperty
    a_float_gap: assert property (p_float_gap) // RULE_22
        else $error("Drive began before memory floated.");

    property p_addr_before_sel;
        @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
        !MEM_SEL_N_O && $past(!MEM_SEL_N_O) |-> $stable(MEM_ADDR_O);
    endproperty
    a_addr_before_sel: assert property (p_addr_before_sel) // RULE_06
        else $error("Address changed while selected.");

    c_read: cover property (@(posedge CORE_CLK_I) $rose(RSP_VALID_O)
        && MEM_SEL_N_O && $past(MEM_OE_N_O, 2) == 1'b0);
    c_write: cover property (@(posedge CORE_CLK_I)
        $fell(MEM_WRITE_STROBE_N_O));
    c_oe: cover property (@(posedge CORE_CLK_I) $fell(MEM_OE_N_O));

endmodule : sram_host_ctrl

// File: tb/sram_dev_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Behavioural memory device with checks on the controller's pin timing.
// ----------------------------------------------------------------------
module sram_dev_model (
    input  wire logic [sram_host_pkg::ADDR_W-1:0] addr_i,
    input  wire logic                             sel_n_i,
    input  wire logic                             oe_n_i,
    input  wire logic                             we_n_i,
    input  wire logic [sram_host_pkg::DATA_W-1:0] data_i,
    input  wire logic                             host_drive_i,
    output logic      [sram_host_pkg::DATA_W-1:0] data_o,
    output logic                                  drive_o,
    output int                                    viol_o
);
    import sram_host_pkg::*;
    logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
    logic              rd_en;
    logic              wr_en;
    logic              armed = 1'b0;
    realtime           t_wr = 0, t_addr = 0, t_data = 0;

    // No clock anywhere: only pin levels start and end an access.
    assign rd_en = !sel_n_i && !oe_n_i && we_n_i;
    assign wr_en = !sel_n_i && !we_n_i;

    initial begin
        drive_o = 1'b0;
        data_o = '0;
        viol_o = 0;
    end

    // Drivers turn on and off alike 3 ns after the enable changes; the bus holds garbage until valid.
    always @(rd_en) begin
        drive_o <= #3 rd_en;
    end
    always @(rd_en or addr_i) begin
        data_o <= #4 ~data_o;
        data_o <= #(SELECT_TO_DATA_MAX_NS) mem.exists(addr_i) ?
                  mem[addr_i] : ~addr_i[DATA_W-1:0];
    end

    // Times are stamped so that the write end can judge set-up margins.
    always @(addr_i) t_addr = $realtime;
    always @(data_i) t_data = $realtime;
    always @(posedge wr_en) begin
        t_wr = $realtime;
        armed = 1'b1;
    end
    always @(negedge wr_en) begin
        if (armed) begin
            if (t_addr > t_wr) viol_o++;
            if ($realtime - t_addr < ADDR_VALID_TO_WRITE_END_NS)
                viol_o++;
            if ($realtime - t_wr < WRITE_PULSE_MIN_NS)
                viol_o++;
            if ($realtime - t_data < DATA_SETUP_TO_WRITE_END_NS)
                viol_o++;
            mem[addr_i] = data_i;
        end
    end

    // Two drivers on the bus at once is a fault of the controller.
    always @(drive_o or host_drive_i)
        if (drive_o === 1'b1 && host_drive_i === 1'b1) viol_o++;
endmodule : sram_dev_model

// File: tb/async_sram_256kx4_port_tb.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Testbench: random traffic compared with a reference memory.
// ----------------------------------------------------------------------
module async_sram_256kx4_port_tb;
    import sram_host_pkg::*;
    logic              clk, vld = 1'b0, wr = 1'b0, rst_n = 1'b0;
    logic              rdy, rv, sel_n, oe_n, we_n, h_oe, m_drv;
    logic [ADDR_W-1:0] addr = '0, m_addr, a;
    logic [DATA_W-1:0] wd = '0, rd, m_do, h_do, bus, last = '0;
    logic [ADDR_W-1:0] q [$];
    logic [DATA_W-1:0] ref_mem [logic [ADDR_W-1:0]];
    int                n_fail = 0, cmp_count = 0, cyc = 0, viol;

    initial begin
        clk = 1'b0;
        forever #(CLK_PERIOD_NS / 2) clk = ~clk;
    end
    // A released bus shows the inverse of its last level, never a hold.
    assign bus = (m_drv === 1'b1) ? m_do :
                 ((h_oe === 1'b1) ? h_do : ~last);
    always @(posedge clk) last <= bus;

    sram_host_ctrl sram_host_ctrl_i (.CORE_CLK_I(clk), .ARST_N_I(rst_n),
        .REQ_VALID_I(vld), .REQ_WRITE_I(wr), .REQ_ADDR_I(addr),
        .REQ_WDATA_I(wd), .REQ_READY_O(rdy), .RSP_VALID_O(rv),
        .RSP_RDATA_O(rd), .MEM_ADDR_O(m_addr), .MEM_SEL_N_O(sel_n),
        .MEM_OE_N_O(oe_n), .MEM_WRITE_STROBE_N_O(we_n), .MEM_DATA_I(bus),
        .MEM_DATA_O(h_do), .MEM_DATA_OE_O(h_oe));
    sram_dev_model sram_dev_model_i (.addr_i(m_addr), .sel_n_i(sel_n),
        .oe_n_i(oe_n), .we_n_i(we_n), .data_i(bus), .host_drive_i(h_oe),
        .data_o(m_do), .drive_o(m_drv), .viol_o(viol));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: saw %0h expected %0h",
                     $time, seen, exp);
        end
    endtask : check

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : complete_run

    // One request held until taken, then a bounded wait for the answer.
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] ad,
                        input logic [DATA_W-1:0] d);
        int n;
        n = 0;
        @(posedge clk);
        vld <= 1'b1;
        wr <= w;
        addr <= ad;
        wd <= d;
        do @(negedge clk); while (rdy !== 1'b1);
        @(posedge clk);
        vld <= 1'b0;
        do begin
            @(negedge clk);
            n++;
        end while (rv !== 1'b1 && n < 20);
        if (rv !== 1'b1) n_fail++;
        if (w) ref_mem[ad] = d;
        else check({28'h0, rd}, {28'h0, ref_mem[ad]});
    endtask : xfer

    // Hang guard: the whole run needs well under a thousand cycles.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            n_fail++;
            complete_run;
        end
    end

    initial begin
        void'($urandom(11560));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            a = (i == 0) ? 18'h00000 : (i == 1) ? 18'h3FFFF : 18'h2AAAA;
            xfer(1'b1, a, 4'hF - DATA_W'(i));
            xfer(1'b0, a, 4'h0);
        end
        $display("boundary test done");
        for (int i = 0; i < 32; i++) begin
            a = ADDR_W'($urandom_range(0, 18'h3FFFF));
            q.push_back(a);
            xfer(1'b1, a, DATA_W'($urandom));
        end
        foreach (q[i]) xfer(1'b0, q[i], 4'h0);
        $display("random test done");
        for (int i = 0; i < 4; i++) xfer(1'b1, q[0], DATA_W'(i + 5));
        xfer(1'b0, q[0], 4'h0);
        $display("overwrite test done");
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 1; i < 5; i++) xfer(1'b0, q[i], 4'h0);
        $display("reset test done");
        check(32'(viol), 32'h0);
        check(32'(viol), 32'h0);
        complete_run;
    end
endmodule : async_sram_256kx4_port_tb
